// File: pkg/ccs_regs.svh
// Purpose: register offsets, field layout, reset values and mode codes of the set-1 capture/compare block
// Assumes: 8-bit word index addressing on the plain register port, 16-bit data
// Notes:   definitions only
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CCS_ADDR_MODE      8'h00
`define CCS_ADDR_COMPARE   8'h01
`define CCS_ADDR_CAPTURE   8'h02
`define CCS_ADDR_STATUS    8'h03
`define CCS_ADDR_MASK      8'h04
`define CCS_ADDR_TIMER     8'h05

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define CCS_MODE_MSB       3
`define CCS_FLAG_BIT       0
`define CCS_MODE_RST       4'h0
`define CCS_WORD_RST       16'h0000
`define CCS_ZERO_PAD_MODE  12'h000
`define CCS_ZERO_PAD_FLAG  15'h0000

// ----------------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------------
`define CCS_MODE_CAP_FALL  4'h4
`define CCS_MODE_CAP_RISE  4'h5
`define CCS_MODE_CAP_R4    4'h6
`define CCS_MODE_CAP_R16   4'h7
`define CCS_MODE_CMP_SET   4'h8
`define CCS_MODE_CMP_CLR   4'h9
`define CCS_MODE_CMP_TGL   4'ha
`define CCS_MODE_RSVD      4'hb
`define CCS_MODE_GRP_OFF   2'h0
`define CCS_MODE_GRP_SW    2'h3

// ----------------------------------------------------------------------------
// prescaler: last count before the capturing edge
// ----------------------------------------------------------------------------
`define CCS_PRE_RST        4'h0
`define CCS_PRE_STEP       4'h1
`define CCS_PRE4_LAST      4'h3
`define CCS_PRE16_LAST     4'hf

`endif

// File: pkg/ccs_pkg.sv
// Purpose: shared types of the set-1 capture/compare block
// Assumes: nothing beyond the register header
// Notes:   the mode field is decoded once into ccs_kind_t
package ccs_pkg;

    // ------------------------------------------------------------------------
    // decoded operating kind of the mode field
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        KIND_OFF      = 4'b0000,
        KIND_CAP_FALL = 4'b0001,
        KIND_CAP_RISE = 4'b0010,
        KIND_CAP_R4   = 4'b0011,
        KIND_CAP_R16  = 4'b0100,
        KIND_CMP_SET  = 4'b0101,
        KIND_CMP_CLR  = 4'b0110,
        KIND_CMP_TGL  = 4'b0111,
        KIND_RSVD     = 4'b1000,
        KIND_CMP_SW   = 4'b1001
    } ccs_kind_t;

endpackage : ccs_pkg

// File: pkg/ccs_if.sv
// Purpose: carrier between the mode logic and the capture edge unit
// Assumes: both ends on CLOCK
// Notes:   restart clears the edge prescaler
`timescale 1ns/1ns
interface ccs_if;
    import ccs_pkg::*;

    ccs_kind_t kind;
    logic      restart;
    logic      cap_strobe;

    modport ctl (output kind, output restart, input cap_strobe);
    modport edg (input kind, input restart, output cap_strobe);
endinterface : ccs_if

// File: hw/ccs_edge.sv
// Purpose: capture input synchroniser, edge detect and rising-edge prescaler
// Assumes: capture pin is asynchronous to CLOCK
// Notes:   strobe is combinational, one cycle per qualifying edge
`timescale 1ns/1ns
`include "ccs_regs.svh"
module ccs_edge (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // pin and carrier
    input  wire logic cap_pin,
    ccs_if.edg        bus
);
    import ccs_pkg::*;

    logic       sync1_r;
    logic       sync2_r;
    logic       prev_r;
    logic       rise;
    logic       fall;
    logic [3:0] pre_r;
    logic       strobe;

    // ------------------------------------------------------------------------
    // synchroniser: only sync2_r reads sync1_r
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= cap_pin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;

    // qualify the edge by mode
    always_comb begin
        case (bus.kind)
            KIND_CAP_FALL: strobe = fall;
            KIND_CAP_RISE: strobe = rise;
            KIND_CAP_R4:   strobe = rise && (pre_r == `CCS_PRE4_LAST);
            KIND_CAP_R16:  strobe = rise && (pre_r == `CCS_PRE16_LAST);
            default:       strobe = 1'b0;
        endcase
    end

    assign bus.cap_strobe = strobe;

    // prescaler counts rising edges; cleared on restart so a mode change starts afresh
    always_ff @(posedge clk) begin
        if (srst || bus.restart) begin
            pre_r <= `CCS_PRE_RST;
        end else if (bus.kind != KIND_CAP_R4 && bus.kind != KIND_CAP_R16) begin
            pre_r <= `CCS_PRE_RST;
        end else if (strobe) begin
            pre_r <= `CCS_PRE_RST;
        end else if (rise) begin
            pre_r <= pre_r + `CCS_PRE_STEP;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_div4;
        @(posedge clk) disable iff (srst)
        (bus.kind == KIND_CAP_R4 && strobe) |-> ((pre_r == `CCS_PRE4_LAST) && rise) ##1 (pre_r == `CCS_PRE_RST);
    endproperty
    a_div4: assert property (p_div4) else $error("divide-by-4 capture off count");

    property p_div16;
        @(posedge clk) disable iff (srst)
        (bus.kind == KIND_CAP_R16 && rise && !bus.restart && pre_r == `CCS_PRE16_LAST) |-> strobe ##1 (pre_r == `CCS_PRE_RST);
    endproperty
    a_div16: assert property (p_div16) else $error("divide-by-16 capture missed");
endmodule : ccs_edge

// File: hw/ccs_top.sv
// Purpose: set-1 capture/compare mode logic with register port and interrupt
// Assumes: timer count and its increment pulse come from logic on CLOCK
// Notes:   the timer is read only; nothing here ever clears it
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "ccs_regs.svh"

// How it works
// - Mode 00xx turns capture and compare off, drives the compare output low and clears the prescaler.
// - Mode 0100 captures the timer on every falling capture-input edge.
// - Mode 0101 captures the timer on every rising capture-input edge.
// - Mode 0110 captures on every fourth rising edge.
// - Mode 0111 captures on every sixteenth rising edge.
// - Mode 1000 drives compare output high on match and sets the event flag.
// - Mode 1001 drives compare output low on match and sets the event flag.
// - Mode 1010 inverts compare output on match and sets the event flag.
// - Mode 11xx sets the event flag on match, pin left alone.
// - A compare match never clears or alters the timer count.
module ccs_top (
    // clock and reset
    input  wire logic          CLOCK,
    input  wire logic          SRST,
    // register port
    input  wire logic [7:0]    ADDR,
    input  wire logic [15:0]   WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic      [15:0]   RDATA,
    // timer
    input  wire logic [15:0]   TIMER_COUNT,
    input  wire logic          TIMER_TICK,
    // pins
    input  wire logic          CAPTURE_IN,
    output logic               SET1_COMPARE_OUTPUT_PIN,
    output logic               SET1_COMPARE_OE_N,
    // interrupt and flag
    output logic               SET1_EVENT_FLAG,
    output logic               IRQ
);
    import ccs_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [3:0]  set1_mode_select_r;
    logic [15:0] compare_r;
    logic [15:0] capture_r;
    logic        flag_r;
    logic        mask_r;
    logic        out_r;
    logic        out_nxt;
    logic [15:0] rdata_r;
    ccs_kind_t   kind;
    logic        wr_mode;
    logic        wr_compare;
    logic        wr_status;
    logic        wr_mask;
    logic        restart;
    logic        match;
    logic        cmp_kind;
    logic        drive_kind;
    logic        flag_set;
    logic        cap_take;

    ccs_if link ();

    // ------------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------------
    // upper two bits pick the group; off and software groups ignore the low bits
    always_comb begin
        if (set1_mode_select_r[3:2] == `CCS_MODE_GRP_OFF) begin
            kind = KIND_OFF;
        end else if (set1_mode_select_r[3:2] == `CCS_MODE_GRP_SW) begin
            kind = KIND_CMP_SW;
        end else if (set1_mode_select_r == `CCS_MODE_CAP_FALL) begin
            kind = KIND_CAP_FALL;
        end else if (set1_mode_select_r == `CCS_MODE_CAP_RISE) begin
            kind = KIND_CAP_RISE;
        end else if (set1_mode_select_r == `CCS_MODE_CAP_R4) begin
            kind = KIND_CAP_R4;
        end else if (set1_mode_select_r == `CCS_MODE_CAP_R16) begin
            kind = KIND_CAP_R16;
        end else if (set1_mode_select_r == `CCS_MODE_CMP_SET) begin
            kind = KIND_CMP_SET;
        end else if (set1_mode_select_r == `CCS_MODE_CMP_CLR) begin
            kind = KIND_CMP_CLR;
        end else if (set1_mode_select_r == `CCS_MODE_CMP_TGL) begin
            kind = KIND_CMP_TGL;
        end else begin
            kind = KIND_RSVD;
        end
    end

    // kinds that look at the compare register and those that own the pin
    assign cmp_kind   = (kind == KIND_CMP_SET) || (kind == KIND_CMP_CLR) ||
                        (kind == KIND_CMP_TGL) || (kind == KIND_CMP_SW);
    assign drive_kind = (kind == KIND_CMP_SET) || (kind == KIND_CMP_CLR) ||
                        (kind == KIND_CMP_TGL);

    // ------------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------------
    always_comb begin
        wr_mode    = 1'b0;
        wr_compare = 1'b0;
        wr_status  = 1'b0;
        wr_mask    = 1'b0;
        if (WR && ADDR == `CCS_ADDR_MODE) begin
            wr_mode = 1'b1;
        end else if (WR && ADDR == `CCS_ADDR_COMPARE) begin
            wr_compare = 1'b1;
        end else if (WR && ADDR == `CCS_ADDR_STATUS) begin
            wr_status = 1'b1;
        end else if (WR && ADDR == `CCS_ADDR_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // a change of mode restarts the prescaler, so stale edge counts never leak across modes
    assign restart = (kind == KIND_OFF) ||
                     (wr_mode && WDATA[`CCS_MODE_MSB:0] != set1_mode_select_r);

    // ------------------------------------------------------------------------
    // edge unit
    // ------------------------------------------------------------------------
    assign link.kind    = kind;
    assign link.restart = restart;

    ccs_edge u_edge (
        .clk     (CLOCK),
        .srst    (SRST),
        .cap_pin (CAPTURE_IN),
        .bus     (link.edg)
    );

    assign cap_take = link.cap_strobe;

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------
    // mode field
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            set1_mode_select_r <= `CCS_MODE_RST;
        end else if (wr_mode) begin
            set1_mode_select_r <= WDATA[`CCS_MODE_MSB:0];
        end
    end

    // compare value
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            compare_r <= `CCS_WORD_RST;
        end else if (wr_compare) begin
            compare_r <= WDATA;
        end
    end

    // interrupt mask
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            mask_r <= 1'b0;
        end else if (wr_mask) begin
            mask_r <= WDATA[`CCS_FLAG_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // capture
    // ------------------------------------------------------------------------
    // holds its value while off so software can still read the last capture
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            capture_r <= `CCS_WORD_RST;
        end else if (cap_take) begin
            capture_r <= TIMER_COUNT;
        end
    end

    // ------------------------------------------------------------------------
    // compare
    // ------------------------------------------------------------------------
    // evaluated only on an increment so a stopped timer cannot re-fire every cycle
    assign match = TIMER_TICK && (TIMER_COUNT == compare_r);

    // output latch; the timer count is only ever read, never written back
    always_comb begin
        out_nxt = out_r;
        case (kind)
            KIND_OFF:     out_nxt = 1'b0;
            KIND_CMP_SET: out_nxt = match ? 1'b1 : out_r;
            KIND_CMP_CLR: out_nxt = match ? 1'b0 : out_r;
            KIND_CMP_TGL: out_nxt = match ? ~out_r : out_r;
            default:      out_nxt = out_r;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // event flag and interrupt
    // ------------------------------------------------------------------------
    // reserved and off kinds raise nothing
    assign flag_set = (cmp_kind && match) || cap_take;

    // a new event in the same cycle as the clear wins
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            flag_r <= 1'b0;
        end else if (flag_set) begin
            flag_r <= 1'b1;
        end else if (wr_status && WDATA[`CCS_FLAG_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    assign SET1_EVENT_FLAG         = flag_r;
    assign IRQ                     = flag_r & mask_r;
    assign SET1_COMPARE_OUTPUT_PIN = out_r;
    assign SET1_COMPARE_OE_N       = ~drive_kind;

    // ------------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------------
    // unmapped addresses read zero; reads have no side effects
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            rdata_r <= `CCS_WORD_RST;
        end else if (RD && ADDR == `CCS_ADDR_MODE) begin
            rdata_r <= {`CCS_ZERO_PAD_MODE, set1_mode_select_r};
        end else if (RD && ADDR == `CCS_ADDR_COMPARE) begin
            rdata_r <= compare_r;
        end else if (RD && ADDR == `CCS_ADDR_CAPTURE) begin
            rdata_r <= capture_r;
        end else if (RD && ADDR == `CCS_ADDR_STATUS) begin
            rdata_r <= {`CCS_ZERO_PAD_FLAG, flag_r};
        end else if (RD && ADDR == `CCS_ADDR_MASK) begin
            rdata_r <= {`CCS_ZERO_PAD_FLAG, mask_r};
        end else if (RD && ADDR == `CCS_ADDR_TIMER) begin
            rdata_r <= TIMER_COUNT;
        end else begin
            rdata_r <= `CCS_WORD_RST;
        end
    end

    assign RDATA = rdata_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_off_resets;
        @(posedge CLOCK) disable iff (SRST)
        (kind == KIND_OFF) |-> !cap_take ##1 !out_r;
    endproperty
    a_off_resets: assert property (p_off_resets) else $error("off mode left output or capture active");

    property p_cap_fall;
        @(posedge CLOCK) disable iff (SRST)
        (kind == KIND_CAP_FALL && cap_take) |=> capture_r == $past(TIMER_COUNT) && flag_r;
    endproperty
    a_cap_fall: assert property (p_cap_fall) else $error("falling-edge capture lost");

    property p_cap_rise;
        @(posedge CLOCK) disable iff (SRST)
        (kind == KIND_CAP_RISE && !cap_take) |=> capture_r == $past(capture_r);
    endproperty
    a_cap_rise: assert property (p_cap_rise) else $error("capture changed without an edge");

    property p_cmp_set;
        @(posedge CLOCK) disable iff (SRST)
        (kind == KIND_CMP_SET && match && !wr_mode) |=> out_r && flag_r && !SET1_COMPARE_OE_N;
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("set-on-match failed");

    property p_cmp_clr;
        @(posedge CLOCK) disable iff (SRST)
        (kind == KIND_CMP_CLR && match) |=> !out_r && flag_r;
    endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("clear-on-match failed");

    property p_cmp_tgl;
        @(posedge CLOCK) disable iff (SRST)
        (kind == KIND_CMP_TGL && match) |=> out_r != $past(out_r) && flag_r;
    endproperty
    a_cmp_tgl: assert property (p_cmp_tgl) else $error("toggle-on-match failed");

    property p_cmp_sw;
        @(posedge CLOCK) disable iff (SRST)
        (kind == KIND_CMP_SW && match && !wr_mode) |=> flag_r && out_r == $past(out_r) && SET1_COMPARE_OE_N;
    endproperty
    a_cmp_sw: assert property (p_cmp_sw) else $error("software compare touched the pin");

    property p_match_def;
        @(posedge CLOCK) disable iff (SRST)
        (cmp_kind && TIMER_TICK && TIMER_COUNT == compare_r && wr_status && WDATA[`CCS_FLAG_BIT]) |=> flag_r;
    endproperty
    a_match_def: assert property (p_match_def) else $error("match flag dropped");

    property p_rsvd;
        @(posedge CLOCK) disable iff (SRST)
        (kind == KIND_RSVD && !flag_r) |=> !flag_r && out_r == $past(out_r);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode produced activity");

    property p_irq;
        @(posedge CLOCK) disable iff (SRST)
        (flag_set && mask_r && !wr_mask) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked event did not interrupt");
endmodule : ccs_top

// File: tb/ccs_pin_model.sv
// Purpose: far-side source that drives the capture input pin
// Assumes: runs on the bench clock
// Notes:   pulses 8 cycles high, 8 low; pin idles low outside trains
`timescale 1ns/1ns
module ccs_pin_model (
    // clock
    input  wire logic       clk,
    // request from the bench
    input  wire logic       start,
    input  wire logic [4:0] count,
    // pin side
    output logic            pin,
    output logic            busy
);
    logic [4:0] left_r  = 5'h00;
    logic [3:0] phase_r = 4'h0;

    // long pulses, so the two-flop synchroniser can never miss one
    always_ff @(posedge clk) begin
        if (start) begin
            left_r  <= count;
            phase_r <= 4'h0;
        end else if (left_r != 5'h00) begin
            phase_r <= phase_r + 4'h1;
            if (phase_r == 4'hf) left_r <= left_r - 5'h01;
        end
    end
    assign busy = start || (left_r != 5'h00);
    assign pin  = (left_r != 5'h00) && !phase_r[3];   // low between trains
endmodule : ccs_pin_model

// File: tb/testbench.sv
// Purpose: self-checking bench for the set-1 capture/compare block
// Assumes: read data stand one cycle after the read strobe
// Notes:   the bench plays the timer; it ticks only where a test asks
`timescale 1ns/1ns
`include "ccs_regs.svh"
module testbench;
    logic        CLOCK       = 1'b0;
    logic        SRST        = 1'b1;
    logic [7:0]  ADDR        = 8'h00;
    logic [15:0] WDATA       = 16'h0000;
    logic        WR          = 1'b0;
    logic        RD          = 1'b0;
    logic [15:0] TIMER_COUNT = 16'h0000;
    logic        TIMER_TICK  = 1'b0;
    logic        start       = 1'b0;
    logic [4:0]  count       = 5'h00;
    logic [15:0] RDATA, d;
    logic        CAPTURE_IN, pin, oe_n, flag, irq, busy;
    int          miscompares = 0;
    int          checked     = 0;
    logic [7:0]  rs_addr [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0f};
    logic [3:0]  cm_mode [8] = '{4'h8, 4'h9, 4'ha, 4'hc, 4'hf, 4'hb, 4'h0, 4'h3};
    logic        cm_pin  [8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic        cm_flag [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    always #25 CLOCK = ~CLOCK;

    ccs_top i_dut (.CLOCK(CLOCK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .TIMER_COUNT(TIMER_COUNT), .TIMER_TICK(TIMER_TICK), .CAPTURE_IN(CAPTURE_IN),
        .SET1_COMPARE_OUTPUT_PIN(pin), .SET1_COMPARE_OE_N(oe_n), .SET1_EVENT_FLAG(flag), .IRQ(irq));
    ccs_pin_model i_src (.clk(CLOCK), .start(start), .count(count), .pin(CAPTURE_IN), .busy(busy));

    // ------------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge CLOCK);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'b1;
        @(posedge CLOCK);
        WR    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge CLOCK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLOCK);
        RD   <= 1'b0;
        #1;
        v = RDATA;   // only valid in this one cycle
    endtask : rd

    task automatic tick(input logic [15:0] v, input logic t);
        @(posedge CLOCK);
        TIMER_COUNT <= v;
        TIMER_TICK  <= t;
        @(posedge CLOCK);
        TIMER_TICK  <= 1'b0;
        #1;
    endtask : tick

    // timer shows v at the rising edge and ~v at the falling one
    task automatic run(input logic [4:0] n, input logic [15:0] v);
        @(posedge CLOCK);
        TIMER_COUNT <= v;
        start       <= 1'b1;
        count       <= n;
        @(posedge CLOCK);
        start <= 1'b0;
        repeat (5) @(posedge CLOCK);
        TIMER_COUNT <= ~v;
        for (int k = 0; k < 600 && busy; k++) @(posedge CLOCK);
        if (busy) begin
            miscompares++;
            $display("mismatch pulse train still busy");
            finish_test();
        end
        repeat (5) @(posedge CLOCK);
        #1;
    endtask : run

    task automatic cap(input logic [3:0] m, input logic [4:0] n, input logic [15:0] v,
                       input logic [15:0] e, input logic f);
        wr(`CCS_ADDR_MODE, 16'h0000);
        wr(`CCS_ADDR_MODE, {12'h000, m});
        wr(`CCS_ADDR_STATUS, 16'h0001);
        if (n > 5'h01) run(n - 5'h01, 16'h0000);
        chk("flag before last edge", {15'h0000, flag}, 16'h0000);
        run(5'h01, v);
        rd(`CCS_ADDR_CAPTURE, d);
        chk("capture", d, e);
        chk("capture flag", {15'h0000, flag}, {15'h0000, f});
        $display("test capture mode %h done", m);
    endtask : cap

    initial begin
        repeat (20) @(posedge CLOCK);
        SRST <= 1'b0;
        foreach (rs_addr[i]) begin
            rd(rs_addr[i], d);
            chk("reset read", d, 16'h0000);
        end
        chk("reset pins", {13'h0000, pin, oe_n, irq}, 16'h0002);
        $display("test reset done");
        cap(4'h5, 5'd1, 16'h1111, 16'h1111, 1'b1);
        cap(4'h4, 5'd1, 16'h2222, 16'hdddd, 1'b1);
        cap(4'h6, 5'd4, 16'h4444, 16'h4444, 1'b1);
        cap(4'h7, 5'd16, 16'h7777, 16'h7777, 1'b1);
        cap(4'hb, 5'd1, 16'h3333, 16'h7777, 1'b0);
        cap(4'h2, 5'd1, 16'h5555, 16'h7777, 1'b0);
        wr(`CCS_ADDR_COMPARE, 16'h0123);
        wr(`CCS_ADDR_MASK, 16'h0001);
        rd(`CCS_ADDR_COMPARE, d);
        chk("compare readback", d, 16'h0123);
        rd(`CCS_ADDR_MASK, d);
        chk("mask readback", d, 16'h0001);
        foreach (cm_mode[i]) begin
            wr(`CCS_ADDR_MODE, {12'h000, cm_mode[i]});
            wr(`CCS_ADDR_STATUS, 16'h0001);
            tick(16'h0123, 1'b0);
            tick(16'h0122, 1'b1);
            chk("flag without match", {15'h0000, flag}, 16'h0000);
            tick(16'h0123, 1'b1);
            chk("compare pin", {15'h0000, pin}, {15'h0000, cm_pin[i]});
            chk("compare flag", {15'h0000, flag}, {15'h0000, cm_flag[i]});
            chk("compare irq", {15'h0000, irq}, {15'h0000, cm_flag[i]});
            chk("enable", {15'h0000, oe_n}, {15'h0000, !(cm_mode[i] inside {4'h8, 4'h9, 4'ha})});
        end
        wr(`CCS_ADDR_MODE, 16'h000c);
        tick(16'h0123, 1'b1);
        rd(`CCS_ADDR_TIMER, d);
        chk("timer after match", d, 16'h0123);
        wr(`CCS_ADDR_MASK, 16'h0000);
        chk("masked irq", {15'h0000, irq, flag}, 16'h0001);
        wr(`CCS_ADDR_STATUS, 16'h0001);
        chk("cleared flag", {15'h0000, flag}, 16'h0000);
        $display("test compare done");
        finish_test();
    end
endmodule : testbench
